/* src/crb_cond_eval.sv */
// Purpose: evaluates the four-bit condition against the status flags
// Assumes: flags ordered negative, zero, carry, overflow
// Notes:   purely combinational
`default_nettype none
module crb_cond_eval (
   input  wire logic [3:0] cond,
   input  wire logic [3:0] flags,
   output logic            pass
);
   wire n = flags[3];
   wire z = flags[2];
   wire c = flags[1];
   wire v = flags[0];
   always_comb begin
      unique case (cond)
         4'h0: pass = z;
         4'h1: pass = !z;
         4'h2: pass = c;
         4'h3: pass = !c;
         4'h4: pass = n;
         4'h5: pass = !n;
         4'h6: pass = v;
         4'h7: pass = !v;
         4'h8: pass = c && !z;
         4'h9: pass = !c || z;
         4'ha: pass = n == v;
         4'hb: pass = n != v;
         4'hc: pass = !z && (n == v);
         4'hd: pass = z || (n != v);
         4'he: pass = 1'b1;
         4'hf: pass = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* src/crb_decoder.sv */
// Purpose: decode and execute coprocessor register moves and barrier traps
// Assumes: one instruction presented per issue pulse, held while stalled
// Notes:   the system control unit answers coprocessor 15 internally
// How it works
// - moves execute only when the condition field passes
// - move recognised by class 1110 with bit 4 set; condition at top
// - direction bit set moves coprocessor value into a core register
// - direction bit clear moves core register value into the coprocessor
// - fixed field layout for number, core register and coprocessor fields
// - operation and register fields pass through uninterpreted
// - only internal coprocessor is the system control unit, number 15
// - move to program counter copies top four bits into status flags only
// - moves to unit 15 complete in one cycle; external moves stall while ext_busy
// - trap with comment f00000 flushes all prefetch state
// - trap with comment f00001 flushes range low inclusive to high exclusive
// - external move neither accepted nor busy with passing condition takes undefined trap
`default_nettype none
module crb_decoder
   import crb_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     issue,
   input  wire logic [31:0]              instr,
   input  wire logic [31:0]              core_reg_value,
   input  wire logic [31:0]              range_low_register,
   input  wire logic [31:0]              range_high_register,
   input  wire logic                     ext_accept,
   input  wire logic                     ext_busy,
   input  wire logic [31:0]              ext_read_data,
   input  wire logic [31:0]              sys_ctrl_read_data,
   output logic                          stall,
   output crb_pkg::crb_move_fields_t     move_fields,
   output logic                          move_req,
   output logic                          move_dir_to_core,
   output logic                          move_to_sys_ctrl,
   output logic [31:0]                   move_write_data,
   output logic                          reg_write,
   output logic [3:0]                    reg_write_index,
   output logic [31:0]                   reg_write_data,
   output logic [3:0]                    status_flags,
   output logic                          undef_trap,
   output logic                          full_flush,
   output crb_pkg::crb_flush_t           range_flush,
   output logic                          trap_other
);
   import crb_pkg::*;

   logic                 cond_pass;
   crb_move_fields_t     move_fields_ff;
   logic                 move_req_ff, dir_ff, sys_ff, stall_ff;
   logic [31:0]          wdata_ff, rwdata_ff;
   logic                 rw_ff, undef_ff, full_ff, trap_ff;
   logic [3:0]           rwidx_ff, flags_ff;
   crb_flush_t           range_ff;

   crb_cond_eval u_cond (
      .cond  (instr[COND_HI:COND_LO]),
      .flags (flags_ff),
      .pass  (cond_pass)
   );

   wire is_move    = (instr[CLASS_HI:CLASS_LO] == CLASS_REG_MOVE) && instr[MARK_BIT];
   wire is_trap    = instr[CLASS_HI:CLASS_LO] == CLASS_TRAP;
   wire exec       = issue && cond_pass;
   wire to_core    = instr[DIR_BIT];
   wire [3:0] cpn  = instr[CPNUM_HI:CPNUM_LO];
   wire [3:0] rd   = instr[CORE_REG_HI:CORE_REG_LO];
   wire is_sys     = cpn == SYS_CTRL_NUM;
   wire accepted   = is_sys || (ext_accept && !ext_busy);
   wire bounced    = !is_sys && !ext_accept && !ext_busy;
   wire move_exec  = exec && is_move;
   wire move_done  = move_exec && accepted;
   wire move_wait  = move_exec && !is_sys && ext_busy;
   wire [31:0] rdata = is_sys ? sys_ctrl_read_data : ext_read_data;
   wire to_pc      = rd == PROGRAM_COUNTER;
   // register write only for non-pc destinations
   wire write_core = move_done && to_core && !to_pc;
   // barrier codes in the trap comment field
   wire is_full    = exec && is_trap && (instr[COMMENT_HI:COMMENT_LO] == FULL_BARRIER);
   wire is_range   = exec && is_trap && (instr[COMMENT_HI:COMMENT_LO] == RANGED_BARRIER);
   wire [3:0] nxt_flags = (move_done && to_core && to_pc)
                          ? rdata[FLAG_N_BIT:FLAG_V_BIT] : flags_ff;

   crb_move_fields_t nxt_fields;
   always_comb begin
      // fields handed to the coprocessor untouched
      nxt_fields.coproc_operation_field    = instr[OPC_HI:OPC_LO];
      nxt_fields.first_coproc_reg_field    = instr[CRN_HI:CRN_LO];
      nxt_fields.core_reg                  = rd;
      nxt_fields.coproc_number_field       = cpn;
      nxt_fields.secondary_operation_field = instr[OP2_HI:OP2_LO];
      nxt_fields.second_coproc_reg_field   = instr[CRM_HI:CRM_LO];
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         move_fields_ff <= '0;
         move_req_ff    <= 1'b0;
         dir_ff         <= 1'b0;
         sys_ff         <= 1'b0;
         wdata_ff       <= '0;
         stall_ff       <= 1'b0;
      end else begin
         move_fields_ff <= move_exec ? nxt_fields : move_fields_ff;
         move_req_ff    <= move_done;
         dir_ff         <= move_exec ? to_core : dir_ff;
         sys_ff         <= move_exec ? is_sys : sys_ff;
         wdata_ff       <= (move_exec && !to_core) ? core_reg_value : wdata_ff;
         stall_ff       <= move_wait;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rw_ff     <= 1'b0;
         rwidx_ff  <= '0;
         rwdata_ff <= '0;
         flags_ff  <= FLAGS_RESET;
      end else begin
         rw_ff     <= write_core;
         rwidx_ff  <= write_core ? rd : rwidx_ff;
         rwdata_ff <= write_core ? rdata : rwdata_ff;
         flags_ff  <= nxt_flags;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         undef_ff <= 1'b0;
         full_ff  <= 1'b0;
         range_ff <= '0;
         trap_ff  <= 1'b0;
      end else begin
         undef_ff       <= move_exec && bounced;
         full_ff        <= is_full;
         range_ff.valid <= is_range;
         range_ff.low   <= is_range ? range_low_register : range_ff.low;
         range_ff.high  <= is_range ? range_high_register : range_ff.high;
         trap_ff        <= exec && is_trap && !is_full && !is_range;
      end
   end

   assign move_fields      = move_fields_ff;
   assign move_req         = move_req_ff;
   assign move_dir_to_core = dir_ff;
   assign move_to_sys_ctrl = sys_ff;
   assign move_write_data  = wdata_ff;
   assign stall            = stall_ff;
   assign reg_write        = rw_ff;
   assign reg_write_index  = rwidx_ff;
   assign reg_write_data   = rwdata_ff;
   assign status_flags     = flags_ff;
   assign undef_trap       = undef_ff;
   assign full_flush       = full_ff;
   assign range_flush      = range_ff;
   assign trap_other       = trap_ff;

   a_move_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
      move_done |=> move_req) else $error("move not completed next cycle");
   a_cond_fail_none: assert property (@(posedge core_clk) disable iff (reset)
      (issue && !cond_pass) |=> !move_req && !undef_trap && !full_flush && !range_flush.valid)
      else $error("failed condition had an effect");
   a_pc_flags: assert property (@(posedge core_clk) disable iff (reset)
      (move_done && to_core && to_pc)
         |=> status_flags == $past(rdata[FLAG_N_BIT:FLAG_V_BIT]) && !reg_write)
      else $error("pc move flags wrong");
   a_core_write: assert property (@(posedge core_clk) disable iff (reset)
      (move_done && to_core && !to_pc) |=> reg_write && reg_write_index == $past(rd))
      else $error("core register not written");
   a_no_write_out: assert property (@(posedge core_clk) disable iff (reset)
      (move_done && !to_core) |=> !reg_write && move_write_data == $past(core_reg_value))
      else $error("outgoing move wrong");
   a_busy_stall: assert property (@(posedge core_clk) disable iff (reset)
      move_wait |=> stall && !move_req) else $error("busy move not stalled");
   a_full_flush: assert property (@(posedge core_clk) disable iff (reset)
      is_full |=> full_flush && !range_flush.valid) else $error("full barrier missed");
   a_range_flush: assert property (@(posedge core_clk) disable iff (reset)
      is_range |=> range_flush.valid && range_flush.low == $past(range_low_register))
      else $error("ranged barrier missed");
   a_undef_bounce: assert property (@(posedge core_clk) disable iff (reset)
      (move_exec && bounced) |=> undef_trap && !move_req) else $error("bounce not trapped");
   a_sys_internal: assert property (@(posedge core_clk) disable iff (reset)
      (move_exec && is_sys) |=> move_req && move_to_sys_ctrl) else $error("unit 15 refused");

   // reset and decode path checks
   a_reset_quiet: assert property (@(posedge core_clk)
      reset |=> !move_req && !reg_write && !undef_trap && !stall && !trap_other)
      else $error("pulse during reset");
   a_non_move_quiet: assert property (@(posedge core_clk) disable iff (reset)
      (issue && !is_move) |=> !move_req && !reg_write && !stall && !undef_trap)
      else $error("non-move instruction moved");
   a_dir_capture: assert property (@(posedge core_clk) disable iff (reset)
      move_exec |=> move_dir_to_core == $past(to_core))
      else $error("move direction not captured");
   a_field_layout: assert property (@(posedge core_clk) disable iff (reset)
      move_exec |=> move_fields.core_reg == $past(instr[CORE_REG_HI:CORE_REG_LO])
         && move_fields.coproc_number_field == $past(instr[CPNUM_HI:CPNUM_LO]))
      else $error("move field layout wrong");
   a_fields_pass: assert property (@(posedge core_clk) disable iff (reset)
      move_exec |=> move_fields.first_coproc_reg_field == $past(instr[CRN_HI:CRN_LO])
         && move_fields.second_coproc_reg_field == $past(instr[CRM_HI:CRM_LO]))
      else $error("coprocessor fields altered");
   a_flags_kept: assert property (@(posedge core_clk) disable iff (reset)
      !(move_done && to_core && to_pc) |=> $stable(status_flags))
      else $error("flags changed without pc move");
   a_core_data: assert property (@(posedge core_clk) disable iff (reset)
      write_core |=> reg_write_data == $past(rdata))
      else $error("core write data wrong");
   a_range_high: assert property (@(posedge core_clk) disable iff (reset)
      is_range |=> range_flush.high == $past(range_high_register))
      else $error("ranged barrier high bound wrong");
   a_trap_onehot: assert property (@(posedge core_clk) disable iff (reset)
      (exec && is_trap) |=> $onehot({full_flush, range_flush.valid, trap_other}))
      else $error("trap outcome not unique");
   a_sys_no_stall: assert property (@(posedge core_clk) disable iff (reset)
      (move_exec && is_sys) |=> !stall && !undef_trap)
      else $error("unit 15 stalled or bounced");
endmodule
`default_nettype wire

/* src/crb_pkg.sv */
// Purpose: shared constants and carriers for the coprocessor transfer and barrier decoder
// Assumes: 32-bit instruction words, 4-bit register numbers
// Notes:   field positions and codes used by decoder and testbench
`default_nettype none
package crb_pkg;
   localparam int COND_HI     = 31;
   localparam int COND_LO     = 28;
   localparam int CLASS_HI    = 27;
   localparam int CLASS_LO    = 24;
   localparam int DIR_BIT     = 20;
   localparam int MARK_BIT    = 4;
   localparam int COMMENT_HI  = 23;
   localparam int COMMENT_LO  = 0;
   localparam int OPC_HI      = 23;
   localparam int OPC_LO      = 21;
   localparam int CRN_HI      = 19;
   localparam int CRN_LO      = 16;
   localparam int CORE_REG_HI = 15;
   localparam int CORE_REG_LO = 12;
   localparam int CPNUM_HI    = 11;
   localparam int CPNUM_LO    = 8;
   localparam int OP2_HI      = 7;
   localparam int OP2_LO      = 5;
   localparam int CRM_HI      = 3;
   localparam int CRM_LO      = 0;
   localparam int FLAG_N_BIT  = 31;
   localparam int FLAG_V_BIT  = 28;
   localparam logic [3:0]  CLASS_REG_MOVE = 4'he;
   localparam logic [3:0]  CLASS_TRAP     = 4'hf;
   localparam logic [23:0] FULL_BARRIER   = 24'hf0_0000;
   localparam logic [23:0] RANGED_BARRIER = 24'hf0_0001;
   localparam logic [3:0]  SYS_CTRL_NUM   = 4'hf;
   localparam logic [3:0]  PROGRAM_COUNTER = 4'hf;
   localparam logic [3:0]  FLAGS_RESET    = 4'h0;

   typedef struct packed {
      logic [2:0] coproc_operation_field;
      logic [3:0] first_coproc_reg_field;
      logic [3:0] core_reg;
      logic [3:0] coproc_number_field;
      logic [2:0] secondary_operation_field;
      logic [3:0] second_coproc_reg_field;
   } crb_move_fields_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] low;
      logic [31:0] high;
   } crb_flush_t;
endpackage
`default_nettype wire

/* verif/coproc_reg_transfer_and_barrier_tb.sv */
// Purpose: sequence of moves and traps against expected port values
// Assumes: outputs answer one cycle after the taking edge
// Notes:   no program counter source moves are issued
`default_nettype none
module coproc_reg_transfer_and_barrier_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import crb_pkg::*;
   localparam logic [31:0] RD_W = 32'ha55a_3cc3;
   localparam logic [31:0] SYS_W = 32'h1234_5678;
   localparam logic [31:0] CORE_W = 32'h0bad_f00d;
   logic core_clk = 1'b0, reset = 1'b1, issue = 1'b0, slow = 1'b0, refuse = 1'b0;
   logic [31:0] instr = 32'h0000_0000;
   logic ext_accept, ext_busy, stall, move_req, move_dir_to_core, move_to_sys_ctrl;
   logic reg_write, undef_trap, full_flush, trap_other;
   logic [31:0] ext_read_data, move_write_data, reg_write_data;
   logic [3:0] reg_write_index, status_flags;
   logic [5:0] pulses;
   crb_move_fields_t move_fields;
   crb_flush_t range_flush;
   int mismatches = 0, num_checks = 0, tries;
   assign pulses = {move_req, reg_write, undef_trap, full_flush, range_flush.valid, trap_other};
   always #2 core_clk = ~core_clk;
   crb_copro_model #(.READ_WORD(RD_W)) partner (.core_clk(core_clk), .reset(reset),
      .issue(issue), .instr(instr), .slow(slow), .refuse(refuse), .ext_accept(ext_accept),
      .ext_busy(ext_busy), .ext_read_data(ext_read_data));
   crb_decoder dut (.core_clk(core_clk), .reset(reset), .issue(issue), .instr(instr),
      .core_reg_value(CORE_W), .range_low_register(32'h0000_1000),
      .range_high_register(32'h0000_2000), .ext_accept(ext_accept), .ext_busy(ext_busy),
      .ext_read_data(ext_read_data), .sys_ctrl_read_data(SYS_W), .stall(stall),
      .move_fields(move_fields), .move_req(move_req), .move_dir_to_core(move_dir_to_core),
      .move_to_sys_ctrl(move_to_sys_ctrl), .move_write_data(move_write_data),
      .reg_write(reg_write), .reg_write_index(reg_write_index),
      .reg_write_data(reg_write_data), .status_flags(status_flags),
      .undef_trap(undef_trap), .full_flush(full_flush), .range_flush(range_flush),
      .trap_other(trap_other));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // issue held while the partner busy-waits, dropped at the first edge where ext_busy is low
   task automatic run(input logic [31:0] w);
      logic busy;
      tries = 0;
      @(posedge core_clk);
      issue <= 1'b1;
      instr <= w;
      do begin
         @(posedge core_clk);
         busy = ext_busy;
         tries++;
         if (busy !== 1'b1) issue <= 1'b0;
         @(negedge core_clk);
         chk("stall", 32'(stall), 32'(busy));
      end while (busy === 1'b1 && tries < 8);
      chk("busy_limit", 32'(busy), 32'h0000_0000);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #20000;
      mismatches++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      run(32'hee32_3f55);
      chk("pulses", 32'(pulses), 32'h0000_0030);
      chk("wr_index", 32'(reg_write_index), 32'h0000_0003);
      chk("wr_data", reg_write_data, SYS_W);
      chk("to_sys", 32'(move_to_sys_ctrl), 32'h0000_0001);
      chk("dir", 32'(move_dir_to_core), 32'h0000_0001);
      chk("fields", 32'(move_fields), 32'({3'h1, 4'h2, 4'h3, 4'hf, 3'h2, 4'h5}));
      run(32'hee32_f255);
      chk("pulses", 32'(pulses), 32'h0000_0020);
      chk("flags", 32'(status_flags), 32'h0000_000a);
      chk("to_sys", 32'(move_to_sys_ctrl), 32'h0000_0000);
      run(32'h0e32_3f55);
      chk("pulses", 32'(pulses), 32'h0000_0000);
      // flags hold n and c: never and ge fail, lt passes
      run(32'hfe32_3f55);
      chk("pulses", 32'(pulses), 32'h0000_0000);
      run(32'hae32_3f55);
      chk("pulses", 32'(pulses), 32'h0000_0000);
      run(32'hbe32_3f55);
      chk("pulses", 32'(pulses), 32'h0000_0030);
      chk("flags", 32'(status_flags), 32'h0000_000a);
      run(32'h0ff0_0000);
      chk("pulses", 32'(pulses), 32'h0000_0000);
      run(32'h1e22_4255);
      chk("pulses", 32'(pulses), 32'h0000_0020);
      chk("wdata", move_write_data, CORE_W);
      chk("dir", 32'(move_dir_to_core), 32'h0000_0000);
      @(posedge core_clk);
      slow <= 1'b1;
      run(32'hee32_6255);
      chk("tries", 32'(tries), 32'h0000_0003);
      chk("pulses", 32'(pulses), 32'h0000_0030);
      chk("wr_data", reg_write_data, RD_W);
      @(posedge core_clk);
      slow <= 1'b0;
      refuse <= 1'b1;
      run(32'hee32_6355);
      chk("pulses", 32'(pulses), 32'h0000_0008);
      @(posedge core_clk);
      refuse <= 1'b0;
      // barriers as after writing code, then an ordinary trap
      run(32'heff0_0000);
      chk("pulses", 32'(pulses), 32'h0000_0004);
      run(32'heff0_0001);
      chk("pulses", 32'(pulses), 32'h0000_0002);
      chk("low", range_flush.low, 32'h0000_1000);
      chk("high", range_flush.high, 32'h0000_2000);
      run(32'hef00_0012);
      chk("pulses", 32'(pulses), 32'h0000_0001);
      // reset in mid-run clears flags, then a move still works
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(negedge core_clk);
      chk("rst_flags", 32'(status_flags), 32'(FLAGS_RESET));
      chk("rst_pulses", 32'(pulses), 32'h0000_0000);
      run(32'hee32_3f55);
      chk("pulses", 32'(pulses), 32'h0000_0030);
      chk("wr_data", reg_write_data, SYS_W);
      final_report();
   end
endmodule
`default_nettype wire

/* verif/crb_copro_model.sv */
// Purpose: external coprocessor answering register moves on the core side port
// Assumes: answers in the issue cycle, never claims unit 15
// Notes:   slow busy-waits two cycles on the first move after slow rises or reset, refuse bounces every move
`default_nettype none
module crb_copro_model #(
   parameter logic [31:0] READ_WORD = 32'ha55a_3cc3
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        issue,
   input  wire logic [31:0] instr,
   input  wire logic        slow,
   input  wire logic        refuse,
   output logic             ext_accept,
   output logic             ext_busy,
   output logic [31:0]      ext_read_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] busy_left_ff;
   logic       mine;
   // own number decoded here, other fields left to this side
   assign mine = issue && instr[27:24] == 4'he && instr[4] && instr[11:8] != 4'hf;
   assign ext_busy = mine && !refuse && slow && busy_left_ff != 2'h0;
   assign ext_accept = mine && !refuse && !ext_busy;
   // data line carries the inverted word unless accepting
   assign ext_read_data = ext_accept ? READ_WORD : ~READ_WORD;
   always_ff @(posedge core_clk) begin
      if (reset || !slow) busy_left_ff <= 2'h2;
      else if (ext_busy) busy_left_ff <= busy_left_ff - 2'h1;
   end
endmodule
`default_nettype wire
